// file: design/bil_pkg.sv
package bil_pkg;
  // Internal reset phase bounds, microseconds
  localparam int RST_MIN_US = 15;
  localparam int RST_MAX_US = 150;
  localparam int CLK_MHZ = 50;
  // Least time rounds up: 15 us at 50 MHz
  localparam int RST_CYCLES = (RST_MIN_US * CLK_MHZ * 1000 + 999) / 1000;
  // Security register field
  localparam int SEC_WIDTH = 32;
  localparam int SEC_BOOT_BIT = 5;
  localparam logic [31:0] SEC_RESET = 32'h0000_0000;
  // Image format constants
  localparam logic [31:0] CRC_BYPASS = 32'h0d15_ab1e;
  localparam logic [31:0] CRC_POLY = 32'hedb8_8320;
  localparam logic [31:0] CRC_INIT = 32'hffff_ffff;
  localparam logic [15:0] OTP_START = 16'h0000;
  localparam logic [1:0] SRC_FLASH = 2'h0;
  localparam logic [1:0] SRC_OTP = 2'h1;
  localparam int RAM_AW = 16;
  localparam logic [RAM_AW-1:0] RAM_BASE = 16'h0000;

  typedef enum logic [3:0] {
    BIL_RESET = 4'h0,
    BIL_WAIT = 4'h1,
    BIL_SEC = 4'h2,
    BIL_LEN = 4'h3,
    BIL_PROG = 4'h4,
    BIL_CHK = 4'h5,
    BIL_RUN = 4'h6,
    BIL_ERR = 4'h7
  } bil_state_e;
endpackage

// file: design/bil_crc32.sv
`timescale 1ns/1ns
// Byte-wise reflected CRC-32 register
module bil_crc32 (
  input wire logic clock, // Tile clock
  input wire logic rst, // Sync reset
  input wire logic init, // Preset pulse
  input wire logic byte_en, // Byte valid pulse
  input wire logic [7:0] byte_in, // Data byte
  output logic [31:0] crc_out // Inverted residue
);
  import bil_pkg::*;
  logic [31:0] crc_ff;

  // One byte, LSB first, through the reflected polynomial
  function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c ^ {24'h000000, d};
    for (int i = 0; i < 8; i++)
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    return r;
  endfunction

  // Preset and update
  always_ff @(posedge clock)
  begin
    if (rst || init)
      crc_ff <= CRC_INIT;
    else if (byte_en)
      crc_ff <= crc_step(crc_ff, byte_in);
  end

  assign crc_out = ~crc_ff;
endmodule

// file: design/bil_loader.sv
`timescale 1ns/1ns
// Functional notes
// - Reset low holds device, pulls GPIO down
// - Boot starts 15-150 us after release
// - Secure bit 5 selects OTP, else flash
// - Length word, then s words of program
// - Check word 0x0D15AB1E skips CRC
// - Length and check word LSB first
// - Program at lowest RAM, run there
// - CRC covers length and program bytes
// - Reflected poly, preset ones, inverted result
// - Flash reached through tile 0 ports
// - Security register loaded from OTP first
// - Secure boot fetches from OTP address 0
module bil_loader #(
  parameter int GPIO_W = 8
) (
  input wire logic clock, // Tile clock
  input wire logic rst, // Sync reset, high
  input wire logic rst_pin_n, // External reset pin
  output logic [GPIO_W-1:0] gpio_pulldown, // Pull-down enables
  output logic sec_req, // Security word fetch
  input wire logic sec_valid, // Security word valid
  input wire logic [bil_pkg::SEC_WIDTH-1:0] sec_word, // Security word
  output logic src_req, // Boot byte request
  output logic [1:0] src_sel, // 0 flash on tile 0, 1 OTP
  output logic [15:0] src_start, // Start address in source
  input wire logic src_valid, // Byte valid
  input wire logic [7:0] src_byte, // Byte data
  output logic ram_we, // RAM write strobe
  output logic [bil_pkg::RAM_AW-1:0] ram_addr, // RAM word address
  output logic [31:0] ram_wdata, // RAM write data
  output logic run, // Start execution
  output logic [bil_pkg::RAM_AW-1:0] run_pc, // Start address
  output logic boot_error, // Sticky CRC error
  output logic [bil_pkg::SEC_WIDTH-1:0] sec_reg // Security register
);
  import bil_pkg::*;

  bil_state_e state_ff;
  logic pin_meta_ff, pin_sync_ff;
  logic [15:0] wait_ff;
  logic [31:0] word_ff, len_ff, cnt_ff;
  logic [1:0] bsel_ff;
  logic [SEC_WIDTH-1:0] sec_ff;
  logic err_ff, we_ff;
  logic [RAM_AW-1:0] addr_ff;
  logic [31:0] wdata_ff;
  logic [31:0] crc_val;
  logic take, last_byte, crc_en;
  logic [31:0] full_word;

  // Reset pin synchroniser
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      pin_meta_ff <= 1'b0;
      pin_sync_ff <= 1'b0;
    end
    else
    begin
      pin_meta_ff <= rst_pin_n;
      pin_sync_ff <= pin_meta_ff;
    end
  end

  assign take = src_req && src_valid;
  assign last_byte = (bsel_ff == 2'h3);
  assign full_word = {src_byte, word_ff[31:8]};
  assign crc_en = take && (state_ff == BIL_LEN || state_ff == BIL_PROG);

  bil_crc32 u_crc (
    .clock(clock),
    .rst(rst),
    .init(state_ff == BIL_WAIT),
    .byte_en(crc_en),
    .byte_in(src_byte),
    .crc_out(crc_val)
  );

  // Main sequencer
  always_ff @(posedge clock)
  begin
    if (rst || !pin_sync_ff)
    begin
      state_ff <= BIL_RESET;
      wait_ff <= 16'h0000;
      bsel_ff <= 2'h0;
      word_ff <= 32'h0000_0000;
      len_ff <= 32'h0000_0000;
      cnt_ff <= 32'h0000_0000;
      sec_ff <= SEC_RESET;
      err_ff <= 1'b0;
    end
    else
    begin
      unique case (state_ff)
        BIL_RESET:
          state_ff <= BIL_WAIT;
        BIL_WAIT:
        begin
          wait_ff <= wait_ff + 16'h0001;
          if (wait_ff == 16'(RST_CYCLES - 2))
            state_ff <= BIL_SEC;
        end
        BIL_SEC:
          if (sec_valid)
          begin
            sec_ff <= sec_word;
            state_ff <= BIL_LEN;
          end
        BIL_LEN, BIL_PROG, BIL_CHK:
          if (take)
          begin
            word_ff <= full_word;
            bsel_ff <= bsel_ff + 2'h1;
            if (last_byte)
            begin
              if (state_ff == BIL_LEN)
              begin
                len_ff <= full_word;
                cnt_ff <= 32'h0000_0000;
                state_ff <= (full_word == 32'h0000_0000) ? BIL_CHK : BIL_PROG;
              end
              else if (state_ff == BIL_PROG)
              begin
                cnt_ff <= cnt_ff + 32'h0000_0001;
                if (cnt_ff + 32'h0000_0001 == len_ff)
                  state_ff <= BIL_CHK;
              end
              else if (full_word == CRC_BYPASS || full_word == crc_val)
                state_ff <= BIL_RUN;
              else
              begin
                err_ff <= 1'b1;
                state_ff <= BIL_ERR;
              end
            end
          end
        BIL_RUN, BIL_ERR:
          state_ff <= state_ff;
        default:
          state_ff <= BIL_RESET;
      endcase
    end
  end

  // RAM write path, bottom of RAM upward
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      we_ff <= 1'b0;
      addr_ff <= RAM_BASE;
      wdata_ff <= 32'h0000_0000;
    end
    else
    begin
      we_ff <= take && last_byte && state_ff == BIL_PROG;
      if (take && last_byte && state_ff == BIL_PROG)
      begin
        addr_ff <= RAM_BASE + cnt_ff[RAM_AW-1:0];
        wdata_ff <= full_word;
      end
    end
  end

  assign gpio_pulldown = {GPIO_W{!pin_sync_ff}};
  assign sec_req = (state_ff == BIL_SEC);
  assign src_req = (state_ff == BIL_LEN || state_ff == BIL_PROG || state_ff == BIL_CHK);
  assign src_sel = sec_ff[SEC_BOOT_BIT] ? SRC_OTP : SRC_FLASH;
  assign src_start = OTP_START;
  assign ram_we = we_ff;
  assign ram_addr = addr_ff;
  assign ram_wdata = wdata_ff;
  assign run = (state_ff == BIL_RUN);
  assign run_pc = RAM_BASE;
  assign boot_error = err_ff;
  assign sec_reg = sec_ff;

  a_wait_len: assert property (@(posedge clock) disable iff (rst)
    $rose(state_ff == BIL_SEC) |-> $past(state_ff, RST_CYCLES) == BIL_RESET)
    else $error("boot wait length wrong");
  a_pull_down: assert property (@(posedge clock) disable iff (rst)
    !$past(rst_pin_n, 2) |-> gpio_pulldown == {GPIO_W{1'b1}})
    else $error("pull-down missing in reset");
  a_held_rst: assert property (@(posedge clock) disable iff (rst)
    !pin_sync_ff |=> state_ff == BIL_RESET)
    else $error("left reset while pin low");
  a_src_select: assert property (@(posedge clock) disable iff (rst || !pin_sync_ff)
    sec_req && sec_valid |=> src_req && src_sel == ($past(sec_word[SEC_BOOT_BIT]) ? SRC_OTP : SRC_FLASH))
    else $error("boot source wrong");
  a_err_sticky: assert property (@(posedge clock) disable iff (rst || !pin_sync_ff)
    boot_error |=> boot_error && !run)
    else $error("error flag dropped");
  a_bypass: assert property (@(posedge clock) disable iff (rst || !pin_sync_ff)
    state_ff == BIL_CHK && take && last_byte && full_word == CRC_BYPASS |=> run)
    else $error("bypass word not honoured");
  a_bad_crc: assert property (@(posedge clock) disable iff (rst || !pin_sync_ff)
    state_ff == BIL_CHK && take && last_byte && full_word != CRC_BYPASS && full_word != crc_val
    |=> boot_error && !run)
    else $error("bad crc started program");
  a_run_pc: assert property (@(posedge clock) disable iff (rst)
    run |-> run_pc == RAM_BASE && !src_req)
    else $error("start address wrong");
  a_word_write: assert property (@(posedge clock) disable iff (rst || !pin_sync_ff)
    state_ff == BIL_PROG && take && last_byte |=> ram_we && ram_wdata[31:24] == $past(src_byte))
    else $error("program word order wrong");

  // Fourth byte of a word taken from the source
  sequence s_word_done;
    take && last_byte;
  endsequence

  a_ram_addr: assert property (@(posedge clock) disable iff (rst || !pin_sync_ff)
    s_word_done ##0 (state_ff == BIL_PROG) |=> ram_we && ram_addr == RAM_BASE + $past(cnt_ff[RAM_AW-1:0]))
    else $error("program word address wrong");
  a_len_count: assert property (@(posedge clock) disable iff (rst || !pin_sync_ff)
    s_word_done ##0 (state_ff == BIL_PROG && cnt_ff + 32'h0000_0001 == len_ff) |=> state_ff == BIL_CHK)
    else $error("program length not kept");
  a_sec_first: assert property (@(posedge clock) disable iff (rst || !pin_sync_ff)
    $rose(src_req) |-> $past(sec_req && sec_valid))
    else $error("image fetched before security word");
endmodule

// file: sim/bil_source_model.sv
`timescale 1ns/1ns
// Boot source model: security word and image bytes, with optional stalls
module bil_source_model (
  input wire logic clock, // Tile clock
  input wire logic sec_req, // Security fetch
  output logic sec_valid, // Security valid
  output logic [31:0] sec_word, // Security word
  input wire logic src_req, // Byte request
  input wire logic [15:0] src_start, // Start address
  output logic src_valid, // Byte valid
  output logic [7:0] src_byte, // Byte data
  input wire logic secure, // Secure bit to report
  input wire logic slow // Stall every other cycle
);
  logic [7:0] mem [0:63];
  int ptr = 0;
  bit tog = 0;
  initial
  begin
    sec_valid = 0;
    sec_word = 32'h0;
    src_valid = 0;
    src_byte = 8'h0;
  end
  // Advance on a taken byte, then offer the next or scramble the idle lines
  always @(posedge clock)
  begin
    if (src_req && src_valid)
      ptr = ptr + 1;
    #1;
    tog = !tog;
    sec_valid = sec_req;
    sec_word = sec_req ? {26'h0, secure, 5'h0} : ~sec_word;
    src_valid = src_req && (!slow || tog);
    src_byte = src_valid ? mem[ptr + src_start] : ~src_byte;
  end
endmodule

// file: sim/boot_image_loader_test.sv
`timescale 1ns/1ns
// Boots images from the source model and checks RAM writes and start
module boot_image_loader_test;
  import bil_pkg::*;
  logic clock, rst, rst_pin_n, sec_req, sec_valid, src_req, src_valid, ram_we, run, boot_error, secure, slow;
  logic [7:0] gpio_pulldown, src_byte;
  logic [1:0] src_sel;
  logic [15:0] src_start, ram_addr, run_pc;
  logic [31:0] sec_word, ram_wdata, sec_reg;
  int miscompares = 0;
  int n_compared = 0;
  bil_loader dut_u (.clock, .rst, .rst_pin_n, .gpio_pulldown, .sec_req, .sec_valid, .sec_word, .src_req,
    .src_sel, .src_start, .src_valid, .src_byte, .ram_we, .ram_addr, .ram_wdata, .run, .run_pc, .boot_error,
    .sec_reg);
  bil_source_model mdl_u (.clock, .sec_req, .sec_valid, .sec_word, .src_req, .src_start, .src_valid,
    .src_byte, .secure, .slow);
  // Compare and count
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic results;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Reflected CRC step over one byte
  function automatic logic [31:0] upd(input logic [31:0] c, input logic [7:0] d);
    c = c ^ {24'h0, d};
    for (int i = 0; i < 8; i++)
      c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
    return c;
  endfunction
  function automatic logic [31:0] pw(input int i);
    return 32'h1a2b3c4d ^ (32'(i) * 32'h01030507);
  endfunction
  // Reset, load an n word image (mode 0 good, 1 bypass, 2 bad check) and follow it
  task automatic boot(input logic sec, input logic slw, input int n, input int mode, input logic hard);
    logic [31:0] c, wd;
    int p, w, k;
    @(posedge clock);
    #1;
    rst = hard;
    rst_pin_n = 0;
    secure = sec;
    slow = slw;
    mdl_u.ptr = 0;
    c = CRC_INIT;
    p = 0;
    for (int i = 0; i <= n + 1; i++)
    begin
      wd = i == 0 ? 32'(n) : i <= n ? pw(i - 1) : mode == 1 ? CRC_BYPASS : ~c ^ 32'(mode == 2);
      for (int b = 0; b < 4; b++)
      begin
        mdl_u.mem[p] = wd[8*b +: 8];
        c = upd(c, wd[8*b +: 8]);
        p++;
      end
    end
    repeat (3) @(posedge clock);
    #1;
    rst = 0;
    // Pin alone must hold the sequencer and the pull-downs
    repeat (3) @(posedge clock);
    #2;
    chk("pulldown", 32'hff, gpio_pulldown);
    chk("run_held", 0, run);
    chk("error_cleared", 0, boot_error);
    @(posedge clock);
    #1;
    rst_pin_n = 1;
    k = 0;
    while (!sec_req && k < 8000)
    begin
      @(posedge clock);
      #2;
      k++;
    end
    chk("delay_in_range", 1, k >= 750 && k <= 7500);
    chk("sec_req", 1, sec_req);
    if (!sec_req)
      results;
    chk("pulldown_off", 0, gpio_pulldown);
    w = 0;
    for (k = 0; k < 3000 && !run && !boot_error; k++)
    begin
      @(posedge clock);
      #2;
      if (src_req)
      begin
        chk("src_sel", sec ? SRC_OTP : SRC_FLASH, src_sel);
        chk("src_start", OTP_START, src_start);
      end
      if (ram_we)
      begin
        chk("ram_addr", RAM_BASE + w, ram_addr);
        chk("ram_wdata", pw(w), ram_wdata);
        w++;
      end
    end
    repeat (3) @(posedge clock);
    #2;
    chk("words", n, w);
    chk("run", mode != 2, run);
    chk("boot_error", mode == 2, boot_error);
    chk("run_pc", RAM_BASE, run_pc);
    chk("sec_reg", 32'(sec) << SEC_BOOT_BIT, sec_reg);
    if (k == 3000)
      results;
  endtask
  // Scenarios
  task automatic flash_crc_ok;
    boot(0, 0, 3, 0, 1);
  endtask
  task automatic otp_bypass_slow;
    boot(1, 1, 1, 1, 1);
  endtask
  // Pin-only reset out of a running program
  task automatic bad_crc;
    boot(0, 0, 2, 2, 0);
  endtask
  // Pin-only reset out of the error state
  task automatic empty_image;
    boot(0, 1, 0, 0, 0);
  endtask
  initial
  begin
    clock = 0;
    forever #10 clock = ~clock;
  end
  initial
  begin
    rst = 1;
    rst_pin_n = 0;
    secure = 0;
    slow = 0;
    repeat (4) @(posedge clock);
    flash_crc_ok;
    otp_bypass_slow;
    bad_crc;
    empty_image;
    results;
  end
endmodule
